/* common/fpq_consts.svh */
// Constants for the flash protect, secure region and query host controller
`ifndef FPQ_CONSTS_SVH
`define FPQ_CONSTS_SVH

// Pin widths
`define FPQ_AW          23
`define FPQ_DW          8

// Clock and bus timing, times in ns
`define FPQ_CLK_NS      4
`define FPQ_T_SU_NS     10
`define FPQ_T_WP_NS     35
`define FPQ_T_RDA_NS    100
`define FPQ_T_RST_NS    500
// Least times round up to whole cycles
`define FPQ_CYC(t)      (((t) + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS)
`define FPQ_SU_CYC      `FPQ_CYC(`FPQ_T_SU_NS)
`define FPQ_WP_CYC      `FPQ_CYC(`FPQ_T_WP_NS)
`define FPQ_RDA_CYC     `FPQ_CYC(`FPQ_T_RDA_NS)
`define FPQ_RST_CYC     `FPQ_CYC(`FPQ_T_RST_NS)

// Unlock cycle addresses and command bytes
`define FPQ_UNLK_A1     23'h000555
`define FPQ_UNLK_A2     23'h0002aa
`define FPQ_UNLK_D1     8'haa
`define FPQ_UNLK_D2     8'h55
`define FPQ_CMD_SEC_IN  8'h88
`define FPQ_CMD_SEC_OUT 8'h90
`define FPQ_CMD_IDENT   8'h90
`define FPQ_CMD_EXIT2   8'h00
`define FPQ_CMD_QUERY   8'h98
`define FPQ_CMD_RESET   8'hf0
`define FPQ_QRY_A       23'h000055

// Query identification string location and contents
`define FPQ_QRY_ID_A0   23'h000010
`define FPQ_QRY_ID_A1   23'h000011
`define FPQ_QRY_ID_A2   23'h000012
`define FPQ_QRY_ID_D0   8'h51
`define FPQ_QRY_ID_D1   8'h52
`define FPQ_QRY_ID_D2   8'h59

`endif

/* common/fpq_pkg.sv */
// Types for the flash protect, secure region and query host controller
`include "fpq_consts.svh"

package fpq_pkg;

    // Host operations offered on the command port
    typedef enum logic [2:0] {
        FPQ_OP_READ    = 3'h0,
        FPQ_OP_WRITE   = 3'h1,
        FPQ_OP_SEC_IN  = 3'h2,
        FPQ_OP_SEC_OUT = 3'h3,
        FPQ_OP_IDENT   = 3'h4,
        FPQ_OP_QUERY   = 3'h5,
        FPQ_OP_RESET   = 3'h6
    } fpq_op_t;

    // Mirror of the flash read mode
    typedef enum logic [1:0] {
        FPQ_MD_ARRAY = 2'h0,
        FPQ_MD_IDENT = 2'h1,
        FPQ_MD_QUERY = 2'h2
    } fpq_mode_t;

    // Bus cycle sequencer states
    typedef enum logic [4:0] {
        FPQ_ST_IDLE  = 5'h01,
        FPQ_ST_SETUP = 5'h02,
        FPQ_ST_PULSE = 5'h04,
        FPQ_ST_READ  = 5'h08,
        FPQ_ST_HOLD  = 5'h10
    } fpq_state_t;

    // One bus cycle of a command sequence
    typedef struct packed {
        logic                  last;
        logic                  rd;
        logic [`FPQ_AW-1:0]    addr;
        logic [`FPQ_DW-1:0]    data;
    } fpq_item_t;

endpackage : fpq_pkg

/* design/fpq_host.sv */
// Host controller driving the flash pins for protect, secure region and query access
`timescale 1ns/1ps
`default_nettype none
`include "fpq_consts.svh"

module fpq_host #(
    parameter int unsigned SU_CYC  = `FPQ_SU_CYC,   // Setup and hold cycles
    parameter int unsigned WP_CYC  = `FPQ_WP_CYC,   // Write strobe low cycles
    parameter int unsigned RDA_CYC = `FPQ_RDA_CYC,  // Read access cycles
    parameter int unsigned RST_CYC = `FPQ_RST_CYC   // Clear pin low cycles after reset
) (
    input  wire logic                  mclk_i,           // System clock
    input  wire logic                  reset_n_i,        // Async reset, active low
    input  wire logic                  cmd_valid_i,      // Command request
    input  wire fpq_pkg::fpq_op_t      cmd_op_i,         // Command operation
    input  wire logic [`FPQ_AW-1:0]    cmd_addr_i,       // Read or write address
    input  wire logic [`FPQ_DW-1:0]    cmd_wdata_i,      // Write data
    input  wire logic                  temp_unprotect_i, // Ask for high voltage on clear pin
    input  wire logic                  vcc_ok_i,         // Supply above lockout threshold
    input  wire logic [`FPQ_DW-1:0]    dq_i,             // Flash data in
    output logic                       cmd_ready_o,      // Command taken when valid
    output logic                       cmd_refused_o,    // Command dropped, high while valid with supply low in idle after the clear pin period
    output logic                       rsp_valid_o,      // Read data valid, pulse
    output logic [`FPQ_DW-1:0]         rsp_data_o,       // Read data
    output fpq_pkg::fpq_mode_t         mode_o,           // Flash read mode mirror
    output logic                       secure_o,         // Secure region mapped
    output logic                       query_ok_o,       // Query string matched
    output logic [`FPQ_AW-1:0]         fl_addr_o,        // Flash address
    output logic [`FPQ_DW-1:0]         dq_o,             // Flash data out
    output logic                       dq_oe_o,          // Data out enable
    output logic                       ce_n_o,           // Chip select, active low
    output logic                       oe_n_o,           // Output enable, active low
    output logic                       we_n_o,           // Write strobe, active low
    output logic                       clr_n_o,          // Hardware clear pin, active low
    output logic                       clr_hv_o          // Raise clear pin to high voltage
);
    import fpq_pkg::*;

    // ***********************************
    // Parameter checks
    // ***********************************
    if (SU_CYC < 1 || SU_CYC > 255 || WP_CYC < 1 || WP_CYC > 255 ||
        RDA_CYC < 1 || RDA_CYC > 255 || RST_CYC < 1 || RST_CYC > 65535) begin : g_bad
        $error("fpq_host: cycle counts out of range");
    end

    // ***********************************
    // Sequence table
    // ***********************************
    fpq_state_t         state_reg;
    fpq_state_t         state_next;
    fpq_op_t            op_reg;
    fpq_mode_t          mode_reg;
    logic [1:0]         step_reg;
    logic [7:0]         cnt_reg;
    logic [15:0]        rst_cnt_reg;
    logic               clr_done;
    logic [`FPQ_AW-1:0] uaddr_reg;
    logic [`FPQ_DW-1:0] udata_reg;
    logic               ret_ident_reg;
    logic               secure_reg;
    logic               qry_match_reg;
    fpq_item_t          item;
    logic               cnt_zero;
    logic               done_w;
    logic               take_w;

    // Bus cycle for an operation step
    function automatic fpq_item_t seq_item(input fpq_op_t op, input logic [1:0] st,
                                           input logic [`FPQ_AW-1:0] a, input logic [`FPQ_DW-1:0] d);
        fpq_item_t it;
        it = '{last: 1'b1, rd: 1'b0, addr: a, data: d};
        case (op)
            FPQ_OP_READ: begin
                it.rd = 1'b1;
            end
            FPQ_OP_SEC_IN, FPQ_OP_IDENT, FPQ_OP_SEC_OUT: begin
                it.last = 1'b0;
                if (st == 2'd0) begin
                    it.addr = `FPQ_UNLK_A1;
                    it.data = `FPQ_UNLK_D1;
                end else if (st == 2'd1) begin
                    it.addr = `FPQ_UNLK_A2;
                    it.data = `FPQ_UNLK_D2;
                end else if (st == 2'd2) begin
                    it.addr = `FPQ_UNLK_A1;
                    it.data = (op == FPQ_OP_SEC_IN) ? `FPQ_CMD_SEC_IN :
                              (op == FPQ_OP_IDENT) ? `FPQ_CMD_IDENT : `FPQ_CMD_SEC_OUT;
                    it.last = (op != FPQ_OP_SEC_OUT);
                end else begin
                    it.addr = '0;
                    it.data = `FPQ_CMD_EXIT2;
                    it.last = 1'b1;
                end
            end
            FPQ_OP_QUERY: begin
                // Entry write, then read back the identification string
                it.last = (st == 2'd3);
                it.rd   = (st != 2'd0);
                it.addr = (st == 2'd0) ? `FPQ_QRY_A :
                          (st == 2'd1) ? `FPQ_QRY_ID_A0 :
                          (st == 2'd2) ? `FPQ_QRY_ID_A1 : `FPQ_QRY_ID_A2;
                it.data = `FPQ_CMD_QUERY;
            end
            FPQ_OP_RESET: begin
                it.data = `FPQ_CMD_RESET;
            end
            default: begin
                // Plain single write, never a bypass or accelerated program
                it.last = 1'b1;
            end
        endcase
        return it;
    endfunction : seq_item

    assign item     = seq_item(op_reg, step_reg, uaddr_reg, udata_reg);
    assign cnt_zero = (cnt_reg == 8'h00);
    assign done_w   = (state_reg == FPQ_ST_HOLD) && cnt_zero && item.last;

    // ***********************************
    // Command port
    // ***********************************
    // No command while the clear pin is low or the supply is low
    assign cmd_ready_o   = (state_reg == FPQ_ST_IDLE) && clr_done && vcc_ok_i;
    assign take_w        = cmd_valid_i && cmd_ready_o;
    assign cmd_refused_o = cmd_valid_i && (state_reg == FPQ_ST_IDLE) && clr_done && !vcc_ok_i;

    // Latch the command
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_reg    <= FPQ_OP_READ;
            uaddr_reg <= '0;
            udata_reg <= '0;
        end else if (take_w) begin
            op_reg    <= cmd_op_i;
            uaddr_reg <= cmd_addr_i;
            udata_reg <= cmd_wdata_i;
        end
    end

    // ***********************************
    // Bus cycle sequencer
    // ***********************************
    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FPQ_ST_IDLE:  if (take_w) state_next = FPQ_ST_SETUP;
            FPQ_ST_SETUP: if (cnt_zero) state_next = item.rd ? FPQ_ST_READ : FPQ_ST_PULSE;
            FPQ_ST_PULSE: if (cnt_zero) state_next = FPQ_ST_HOLD;
            FPQ_ST_READ:  if (cnt_zero) state_next = FPQ_ST_HOLD;
            FPQ_ST_HOLD:  if (cnt_zero) state_next = item.last ? FPQ_ST_IDLE : FPQ_ST_SETUP;
            default:      state_next = FPQ_ST_IDLE;
        endcase
    end

    // State, step and phase counter
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= FPQ_ST_IDLE;
            step_reg  <= 2'd0;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg || (state_reg == FPQ_ST_HOLD && cnt_zero)) begin
                case (state_next)
                    FPQ_ST_PULSE: cnt_reg <= 8'(WP_CYC - 1);
                    FPQ_ST_READ:  cnt_reg <= 8'(RDA_CYC - 1);
                    default:      cnt_reg <= 8'(SU_CYC - 1);
                endcase
            end else if (!cnt_zero) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
            if (take_w) begin
                step_reg <= 2'd0;
            end else if (state_reg == FPQ_ST_HOLD && cnt_zero && !item.last) begin
                step_reg <= step_reg + 2'd1;
            end
        end
    end

    // Flash pins from the next state; strobe only with select low and enable high
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ce_n_o    <= 1'b1;
            oe_n_o    <= 1'b1;
            we_n_o    <= 1'b1;
            dq_oe_o   <= 1'b0;
            dq_o      <= '0;
            fl_addr_o <= '0;
        end else begin
            ce_n_o    <= (state_next == FPQ_ST_IDLE);
            oe_n_o    <= (state_next != FPQ_ST_READ);
            we_n_o    <= (state_next != FPQ_ST_PULSE);
            dq_oe_o   <= (state_next != FPQ_ST_IDLE) && !item.rd;
            dq_o      <= item.data;
            fl_addr_o <= item.addr;
        end
    end

    // Read capture and query string check
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp_valid_o   <= 1'b0;
            rsp_data_o    <= '0;
            qry_match_reg <= 1'b0;
        end else begin
            rsp_valid_o <= (state_reg == FPQ_ST_READ) && cnt_zero;
            if (state_reg == FPQ_ST_READ && cnt_zero) begin
                rsp_data_o <= dq_i;
            end
            if (take_w) begin
                qry_match_reg <= 1'b1;
            end else if (state_reg == FPQ_ST_READ && cnt_zero && op_reg == FPQ_OP_QUERY) begin
                if (dq_i != ((step_reg == 2'd1) ? `FPQ_QRY_ID_D0 :
                             (step_reg == 2'd2) ? `FPQ_QRY_ID_D1 : `FPQ_QRY_ID_D2)) begin
                    qry_match_reg <= 1'b0;
                end
            end
        end
    end

    // ***********************************
    // Mode mirror
    // ***********************************
    // Tracks what the flash answers reads with after each sequence
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg      <= FPQ_MD_ARRAY;
            ret_ident_reg <= 1'b0;
            secure_reg    <= 1'b0;
            query_ok_o    <= 1'b0;
        end else if (!vcc_ok_i || !clr_done) begin
            mode_reg   <= FPQ_MD_ARRAY;
            secure_reg <= 1'b0;
            query_ok_o <= 1'b0;
        end else if (done_w) begin
            case (op_reg)
                FPQ_OP_SEC_IN:  secure_reg <= 1'b1;
                FPQ_OP_SEC_OUT: begin
                    secure_reg <= 1'b0;
                    mode_reg   <= FPQ_MD_ARRAY;
                end
                FPQ_OP_IDENT:   mode_reg <= FPQ_MD_IDENT;
                FPQ_OP_QUERY: begin
                    if (mode_reg != FPQ_MD_QUERY) begin
                        ret_ident_reg <= (mode_reg == FPQ_MD_IDENT);
                    end
                    mode_reg   <= FPQ_MD_QUERY;
                    query_ok_o <= qry_match_reg;
                end
                FPQ_OP_RESET: begin
                    mode_reg <= (mode_reg == FPQ_MD_QUERY && ret_ident_reg) ?
                                FPQ_MD_IDENT : FPQ_MD_ARRAY;
                    query_ok_o <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    assign mode_o   = mode_reg;
    assign secure_o = secure_reg;

    // ***********************************
    // Hardware clear pin
    // ***********************************
    // Clear pin low after reset, then high voltage only on request
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_cnt_reg <= '0;
            clr_n_o     <= 1'b0;
            clr_hv_o    <= 1'b0;
        end else begin
            if (!clr_done) begin
                rst_cnt_reg <= rst_cnt_reg + 16'h0001;
            end
            clr_n_o  <= clr_done;
            clr_hv_o <= clr_done && temp_unprotect_i;
        end
    end

    assign clr_done = (rst_cnt_reg == 16'(RST_CYC));

    // ***********************************
    // Assertions
    // ***********************************
    logic [7:0] we_low_cnt;

    // Counts strobe low cycles
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            we_low_cnt <= 8'h00;
        end else begin
            we_low_cnt <= we_n_o ? 8'h00 : we_low_cnt + 8'h01;
        end
    end

    sequence s_done(fpq_op_t o);
        done_w && op_reg == o;
    endsequence

    sequence s_query_exit;
        s_done(FPQ_OP_RESET) ##0 (mode_reg == FPQ_MD_QUERY) ##0 ret_ident_reg;
    endsequence

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    write_gate_a: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
        else $error("strobe low without select or with enable");
    strobe_width_a: assert property ($rose(we_n_o) |-> we_low_cnt == 8'(WP_CYC))
        else $error("write strobe width wrong");
    boot_quiet_a: assert property (!clr_n_o |-> we_n_o && ce_n_o)
        else $error("strobe active while clear pin low");
    lockout_mode_a: assert property (!vcc_ok_i |-> !cmd_ready_o ##1 (mode_o == FPQ_MD_ARRAY && !secure_o))
        else $error("lockout did not return to array read");
    hv_apply_a: assert property (temp_unprotect_i && clr_n_o |=> clr_hv_o)
        else $error("high voltage not applied");
    hv_release_a: assert property (!temp_unprotect_i |=> !clr_hv_o)
        else $error("high voltage not removed");
    sec_map_a: assert property (s_done(FPQ_OP_SEC_IN) ##0 vcc_ok_i |=> secure_o)
        else $error("secure region not mapped");
    clear_unmaps_a: assert property ($rose(clr_n_o) |-> !secure_o ##1 mode_o == FPQ_MD_ARRAY)
        else $error("secure mapping survived reset");
    query_enter_a: assert property (s_done(FPQ_OP_QUERY) ##0 vcc_ok_i |=> mode_o == FPQ_MD_QUERY)
        else $error("query mode not entered");
    query_back_a: assert property (s_query_exit ##0 vcc_ok_i |=> mode_o == FPQ_MD_IDENT)
        else $error("query exit did not return to identification");

endmodule : fpq_host

`default_nettype wire

/* dv/fpq_flash_model.sv */
// Behavioural flash device seen by the host controller
`timescale 1ns/1ps
`default_nettype none
`include "fpq_consts.svh"
module fpq_flash_model #(
    parameter bit FACTORY = 1'b1, // Secure region locked when shipped
    parameter int RD_NS   = 60    // Read access delay, ns
) (
    input  wire logic [`FPQ_AW-1:0] addr_i,   // Address pins
    input  wire logic [`FPQ_DW-1:0] dq_i,     // Data bus level
    input  wire logic               ce_n_i,   // Chip select
    input  wire logic               oe_n_i,   // Output enable
    input  wire logic               we_n_i,   // Write strobe
    input  wire logic               clr_n_i,  // Clear pin
    input  wire logic               hv_i,     // Clear pin at high voltage
    input  wire logic               vcc_ok_i, // Supply above threshold
    output logic [`FPQ_DW-1:0]      dq_o,     // Data driven to the bus
    output logic                    unprot_o  // Protected groups opened
);
    // ****************************************
    // Command state and read paths
    // ****************************************
    localparam logic [7:0] QTAB [23] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0a, 8'h00, 8'h05,
        8'h00, 8'h04, 8'h00};
    logic [1:0] mode = 2'h0;
    logic [1:0] step = 2'h0;
    logic [1:0] old;
    logic       secure = 1'b0;
    logic       pend = 1'b0;
    logic       was;
    logic       ret_id = 1'b0;
    logic [7:0] rd;
    logic [7:0] last = 8'h00;

    // Locked groups of four sectors; only the group holding the first sector
    localparam logic [31:0] GRP_LOCK = 32'h00000001;

    // Addressed locked group opened only while the clear pin sits at high voltage
    assign unprot_o = clr_n_i && hv_i && GRP_LOCK[addr_i[22:18]];

    // Commands land on the rising write strobe
    always @(posedge we_n_i or negedge clr_n_i or negedge vcc_ok_i) begin
        if (!clr_n_i || !vcc_ok_i) begin
            mode = 2'h0;
            secure = 1'b0;
            step = 2'h0;
            pend = 1'b0;
        end else if (!ce_n_i && oe_n_i) begin
            old = step;
            step = 2'h0;
            was = pend;
            pend = 1'b0;
            if (dq_i == `FPQ_CMD_RESET) begin
                mode = (mode == 2'h2 && ret_id) ? 2'h1 : 2'h0;
            end else if (dq_i == `FPQ_CMD_QUERY && mode != 2'h2) begin
                ret_id = mode == 2'h1;
                mode = 2'h2;
            end else if (was && dq_i == `FPQ_CMD_EXIT2) begin
                secure = 1'b0;
                mode = 2'h0;
            end else if (old == 2'h0 && dq_i == `FPQ_UNLK_D1 && addr_i == `FPQ_UNLK_A1) begin
                step = 2'h1;
            end else if (old == 2'h1 && dq_i == `FPQ_UNLK_D2 && addr_i == `FPQ_UNLK_A2) begin
                step = 2'h2;
            end else if (old == 2'h2 && dq_i == `FPQ_CMD_SEC_IN) begin
                secure = 1'b1;
            end else if (old == 2'h2 && dq_i == `FPQ_CMD_IDENT) begin
                mode = 2'h1;
                pend = 1'b1;
            end
        end
    end

    // Read source by mode and mapping; region contents never change
    always @* begin
        if (mode == 2'h2)
            rd = (addr_i inside {[23'h10:23'h26]}) ? QTAB[5'(addr_i - 23'h10)] : 8'h00;
        else if (mode == 2'h1)
            rd = (addr_i[7:0] == 8'h03) ? {FACTORY, 7'h10} : 8'h00;
        else if (secure && addr_i[22:16] == 7'h00)
            rd = (addr_i[15:4] == 12'h000) ? (8'ha0 | addr_i[3:0]) : 8'hff;
        else
            rd = addr_i[7:0] ^ 8'h3c;
    end

    // Released bus shows the inverse of the last byte
    always @(posedge oe_n_i or posedge ce_n_i) last <= dq_o;
    assign #(RD_NS) dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
endmodule : fpq_flash_model
`default_nettype wire

/* dv/fpq_host_tb_top.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "fpq_consts.svh"
module fpq_host_tb_top;
    import fpq_pkg::*;
    // ****************************************
    // Signals, instances and helpers
    // ****************************************
    localparam int RST = 125;
    localparam logic [7:0] QT [23] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0a, 8'h00, 8'h05,
        8'h00, 8'h04, 8'h00};
    logic mclk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i = 1'b0, temp_unprotect_i = 1'b0, vcc_ok_i = 1'b1;
    fpq_op_t            cmd_op_i = FPQ_OP_READ;
    fpq_mode_t          mode_o;
    logic [`FPQ_AW-1:0] cmd_addr_i = '0, fl_addr_o;
    logic [`FPQ_DW-1:0] cmd_wdata_i = '0, dq_i, dq_o, dev_dq, rsp_data_o;
    logic cmd_ready_o, cmd_refused_o, rsp_valid_o, secure_o, query_ok_o, dq_oe_o;
    logic ce_n_o, oe_n_o, we_n_o, clr_n_o, clr_hv_o, unprot;
    int   n_errors = 0, tests_run = 0;
    logic [7:0] rq [$];

    always #2 mclk_i = ~mclk_i;
    // Bus level from whichever side drives
    assign dq_i = dq_oe_o ? dq_o : dev_dq;

    fpq_host #(.RST_CYC(RST)) dut_u (.mclk_i, .reset_n_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i,
        .cmd_wdata_i, .temp_unprotect_i, .vcc_ok_i, .dq_i, .cmd_ready_o, .cmd_refused_o,
        .rsp_valid_o, .rsp_data_o, .mode_o, .secure_o, .query_ok_o, .fl_addr_o, .dq_o, .dq_oe_o,
        .ce_n_o, .oe_n_o, .we_n_o, .clr_n_o, .clr_hv_o);
    fpq_flash_model dev_u (.addr_i(fl_addr_o), .dq_i(dq_i), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .clr_n_i(clr_n_o), .hv_i(clr_hv_o), .vcc_ok_i(vcc_ok_i),
        .dq_o(dev_dq), .unprot_o(unprot));

    task automatic check_val(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_val

    task automatic complete_run();
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // Bounded wait for idle, gathering read pulses
    task automatic wait_ready(output int k);
        for (k = 0; k < 3000 && cmd_ready_o !== 1'b1; k++) begin
            @(negedge mclk_i);
            if (rsp_valid_o === 1'b1) rq.push_back(rsp_data_o);
        end
        if (cmd_ready_o !== 1'b1) begin
            n_errors++;
            complete_run();
        end
    endtask : wait_ready

    task automatic run_cmd(input fpq_op_t op, input logic [22:0] a, input logic [7:0] d);
        int k;
        wait_ready(k);
        rq.delete();
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_wdata_i = d;
        cmd_valid_i = 1'b1;
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        wait_ready(k);
    endtask : run_cmd

    task automatic read_chk(input logic [22:0] a, input logic [7:0] exp, input string what);
        run_cmd(FPQ_OP_READ, a, 8'h00);
        check_val(what, (rq.size() == 1) ? rq[0] : 8'hxx, exp);
    endtask : read_chk

    task automatic chk_md(input string what, input logic [7:0] exp);
        check_val(what, {5'h0, secure_o, mode_o}, exp);
    endtask : chk_md

    task automatic wait_hv(input logic v);
        int k;
        for (k = 0; k < 200 && clr_hv_o !== v; k++) @(negedge mclk_i);
        if (clr_hv_o !== v) begin
            n_errors++;
            complete_run();
        end
    endtask : wait_hv

    // Write strobe low only with chip select low and output enable high
    always @(negedge mclk_i)
        if (we_n_o === 1'b0) check_val("write qualifiers", {6'h0, ce_n_o, oe_n_o}, 8'h01);

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        int k;
        reset_n_i = 1'b0;
        repeat (12) @(negedge mclk_i);
        check_val("pins in reset", {4'h0, clr_n_o, ce_n_o, oe_n_o, we_n_o}, 8'h07);
        reset_n_i = 1'b1;
        wait_ready(k);
        check_val("clear pin length", 8'(k), 8'(RST));
        chk_md("mode after reset", 8'h00);
    endtask : t_reset

    task automatic t_query();
        int k;
        run_cmd(FPQ_OP_QUERY, '0, '0);
        check_val("string length", 8'(rq.size()), 8'h03);
        for (k = 0; k < 3; k++) check_val("query string", rq[k], QT[k]);
        check_val("query state", {5'h0, query_ok_o, mode_o}, 8'h06);
        for (k = 3; k < 23; k++) read_chk(23'h10 + 23'(k), QT[k], "query table");
        run_cmd(FPQ_OP_RESET, 23'h7abcde, '0);
        check_val("state after reset cmd", {5'h0, query_ok_o, mode_o}, 8'h00);
        read_chk(23'h000044, 8'h78, "array read");
    endtask : t_query

    task automatic t_ident();
        run_cmd(FPQ_OP_IDENT, '0, '0);
        read_chk(23'h000003, 8'h90, "factory flag");
        run_cmd(FPQ_OP_QUERY, '0, '0);
        chk_md("query from ident", 8'(FPQ_MD_QUERY));
        run_cmd(FPQ_OP_RESET, '0, '0);
        chk_md("back to ident", 8'(FPQ_MD_IDENT));
        read_chk(23'h000003, 8'h90, "ident again");
        run_cmd(FPQ_OP_RESET, '0, '0);
        chk_md("ident left", 8'h00);
    endtask : t_ident

    task automatic t_secure();
        run_cmd(FPQ_OP_SEC_IN, '0, '0);
        chk_md("region mapped", 8'h04);
        read_chk(23'h000005, 8'ha5, "serial byte");
        read_chk(23'h000020, 8'hff, "unavailable byte");
        run_cmd(FPQ_OP_WRITE, 23'h000005, 8'h00);
        read_chk(23'h000005, 8'ha5, "locked byte");
        run_cmd(FPQ_OP_SEC_OUT, '0, '0);
        chk_md("region unmapped", 8'h00);
        read_chk(23'h000005, 8'h39, "first sector");
    endtask : t_secure

    task automatic t_lockout();
        int k;
        run_cmd(FPQ_OP_SEC_IN, '0, '0);
        vcc_ok_i = 1'b0;
        cmd_valid_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        check_val("lockout", {3'h0, cmd_refused_o, cmd_ready_o, secure_o, mode_o}, 8'h10);
        cmd_valid_i = 1'b0;
        vcc_ok_i = 1'b1;
        wait_ready(k);
        read_chk(23'h000005, 8'h39, "read after lockout");
    endtask : t_lockout

    task automatic t_unprot();
        temp_unprotect_i = 1'b1;
        wait_hv(1'b1);
        read_chk(23'h030005, 8'h39, "sector in group");
        check_val("high voltage", {6'h0, clr_n_o, unprot}, 8'h03);
        temp_unprotect_i = 1'b0;
        wait_hv(1'b0);
        check_val("protection back", {6'h0, clr_n_o, unprot}, 8'h02);
    endtask : t_unprot

    // Main sequence, with a mid-run hardware reset before the unprotect scenario
    initial begin
        t_reset();
        t_query();
        t_ident();
        t_secure();
        t_lockout();
        run_cmd(FPQ_OP_SEC_IN, '0, '0);
        t_reset();
        read_chk(23'h000005, 8'h39, "after hard reset");
        t_unprot();
        complete_run();
    end
endmodule : fpq_host_tb_top
`default_nettype wire
